// ==== hdl/adsic_regs.svh ====
// constants of the serial instruction and control block
`ifndef ADSIC_REGS_SVH
`define ADSIC_REGS_SVH
// instruction fields, bit 0 is the first bit shifted in
`define ADSIC_INSTR_W 8
`define ADSIC_CMD_BIT 4
`define ADSIC_OP_CAL 3'h0
`define ADSIC_OP_ZERO 3'h1
`define ADSIC_OP_PWRUP 3'h2
`define ADSIC_OP_PWRDN 3'h3
`define ADSIC_OP_STATUS 3'h4
`define ADSIC_OP_SIGN 3'h5
`define ADSIC_OP_ACQ 3'h6
`define ADSIC_OP_MODE 3'h7
`define ADSIC_SEL_12 2'h0
`define ADSIC_SEL_16 2'h1
`define ADSIC_SEL_8 2'h2
// acquisition lengths in conversion clocks
`define ADSIC_ACQ_6 6'h06
`define ADSIC_ACQ_10 6'h0a
`define ADSIC_ACQ_18 6'h12
`define ADSIC_ACQ_34 6'h22
`define ADSIC_ACQ_SEL_RST 2'h1
// core timing in conversion clocks
`define ADSIC_CONV12_CCLKS 6'h2c
`define ADSIC_CONV8_CCLKS 6'h15
`define ADSIC_CAL_CCLKS 6'h3f
`define ADSIC_ZERO_CCLKS 6'h10
// word lengths
`define ADSIC_WORD_W 17
`define ADSIC_LEN_8 5'h08
`define ADSIC_LEN_12 5'h0c
`define ADSIC_LEN_16 5'h10
`define ADSIC_LEN_RST 5'h0d
`define ADSIC_CAL_JUNK 17'h0a5c3
`endif

// ==== hdl/adsic_pkg.sv ====
// types of the serial instruction and control block
package adsic_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_CAL} adsic_state_t;
  typedef enum logic [1:0] {FMT_8, FMT_12, FMT_16} adsic_fmt_t;
endpackage : adsic_pkg

// ==== hdl/adsic_core.sv ====
// serial instruction decode, configuration and conversion sequencing
`timescale 1ns/1ps
`include "adsic_regs.svh"
module adsic_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serial_clock,
  input wire logic cs_b,
  input wire logic serial_instr_in,
  input wire logic conv_b,
  input wire logic power_down_pin,
  input wire logic conversion_clock,
  input wire logic [12:0] adc_result,
  output logic serial_data_out,
  output logic conv_done,
  output logic converter_enable,
  output logic [3:0] mux_select,
  output logic test_drive_en,
  output logic result_valid
);
  import adsic_pkg::*;

  // ----------------------------------------------------------------
  // link side, on the serial clock
  // ----------------------------------------------------------------
  logic link_clr;
  logic [4:0] bit_cnt_reg;
  logic [7:0] in_reg;
  logic [7:0] instr_reg;
  logic trig_reg;
  logic instr_tgl_reg;
  logic pend_reg;
  logic ack_tgl_reg;
  logic [16:0] shadow_reg;
  logic [4:0] shadow_len_reg;
  logic [16:0] shift_reg;
  logic [4:0] len_reg;
  logic do_reg;
  logic [16:0] xfer_word_reg;
  logic [4:0] xfer_len_reg;
  logic pub_tgl_reg;
  wire frame_start = (bit_cnt_reg == 5'h00);
  // pending flag is held quasi-static; the word under it never moves while it is high
  // a link-side synchroniser would stall with the stopped link clock and send the result one frame late
  wire pub_pending = pend_reg;
  wire [16:0] start_word = pub_pending ? xfer_word_reg : shadow_reg;
  wire [4:0] start_len = pub_pending ? xfer_len_reg : shadow_len_reg;
  wire [4:0] cur_len = frame_start ? start_len : len_reg;
  wire frame_last = (bit_cnt_reg == (cur_len - 5'h01));
  wire instr_last = (bit_cnt_reg == 5'h07);

  // counter cleared while select is high so each framed transfer starts aligned
  assign link_clr = cs_b | ~rst_b;

  always_ff @(posedge serial_clock or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_reg <= 5'h00;
      in_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= frame_last ? 5'h00 : bit_cnt_reg + 5'h01;
      if (bit_cnt_reg < 5'h08) begin
        in_reg[bit_cnt_reg[2:0]] <= serial_instr_in;
      end
    end
  end

  // word and length crossing in through a toggle handshake
  always_ff @(posedge serial_clock or negedge rst_b) begin
    if (!rst_b) begin
      instr_reg <= 8'h00;
      trig_reg <= 1'b0;
      instr_tgl_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      shadow_reg <= 17'h00000;
      shadow_len_reg <= `ADSIC_LEN_RST;
      shift_reg <= 17'h00000;
      len_reg <= `ADSIC_LEN_RST;
      do_reg <= 1'b0;
    end else begin
      if (instr_last) begin
        instr_reg <= {serial_instr_in, in_reg[6:0]};
        trig_reg <= conv_b;
        instr_tgl_reg <= ~instr_tgl_reg;
      end
      if (frame_start) begin
        if (pub_pending) begin
          shadow_reg <= xfer_word_reg;
          shadow_len_reg <= xfer_len_reg;
          ack_tgl_reg <= ~ack_tgl_reg;
        end
        shift_reg <= {start_word[15:0], 1'b0};
        do_reg <= start_word[16];
        len_reg <= start_len;
      end else begin
        shift_reg <= {shift_reg[15:0], 1'b0};
        do_reg <= shift_reg[16];
      end
    end
  end
  assign serial_data_out = do_reg;

  // ----------------------------------------------------------------
  // synchronisers into the system clock
  // ----------------------------------------------------------------
  logic ins_s1_reg, ins_s2_reg, ins_s3_reg;
  logic ack_s1_reg, ack_s2_reg;
  logic conversion_clock_s1_reg, conversion_clock_s2_reg, conversion_clock_s3_reg;
  logic pd_s1_reg, pd_s2_reg, pd_s3_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      {ins_s1_reg, ins_s2_reg, ins_s3_reg} <= 3'h0;
      {ack_s1_reg, ack_s2_reg} <= 2'h0;
      {conversion_clock_s1_reg, conversion_clock_s2_reg, conversion_clock_s3_reg} <= 3'h0;
      {pd_s1_reg, pd_s2_reg, pd_s3_reg} <= 3'h0;
    end else begin
      {ins_s1_reg, ins_s2_reg, ins_s3_reg} <= {instr_tgl_reg, ins_s1_reg, ins_s2_reg};
      {ack_s1_reg, ack_s2_reg} <= {ack_tgl_reg, ack_s1_reg};
      {conversion_clock_s1_reg, conversion_clock_s2_reg, conversion_clock_s3_reg} <= {conversion_clock, conversion_clock_s1_reg, conversion_clock_s2_reg};
      {pd_s1_reg, pd_s2_reg, pd_s3_reg} <= {power_down_pin, pd_s1_reg, pd_s2_reg};
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  // the instruction register is stable for at least eight serial clocks after the toggle
  wire instr_evt = ins_s2_reg ^ ins_s3_reg;
  wire conversion_clock_tick = conversion_clock_s2_reg & ~conversion_clock_s3_reg;
  wire pd_fall = pd_s3_reg & ~pd_s2_reg;
  wire [2:0] op = {instr_reg[5], instr_reg[6], instr_reg[7]};
  wire [1:0] fsel = {instr_reg[6], instr_reg[7]};
  wire is_cmd = instr_reg[`ADSIC_CMD_BIT];
  wire act = instr_evt & ~trig_reg;
  wire do_conv = act & ~is_cmd;
  wire do_cal = act & is_cmd & (op == `ADSIC_OP_CAL);
  wire do_zero = act & is_cmd & (op == `ADSIC_OP_ZERO);
  wire do_pwrup = act & is_cmd & (op == `ADSIC_OP_PWRUP);
  wire do_pwrdn = act & is_cmd & (op == `ADSIC_OP_PWRDN);
  wire do_status = act & is_cmd & (op == `ADSIC_OP_STATUS);
  wire do_sign = act & is_cmd & (op == `ADSIC_OP_SIGN);
  wire do_acq = act & is_cmd & (op == `ADSIC_OP_ACQ);
  wire do_mode = act & is_cmd & (op == `ADSIC_OP_MODE);

  // ----------------------------------------------------------------
  // configuration and sequencing state
  // ----------------------------------------------------------------
  adsic_state_t state_reg, state_next;
  adsic_fmt_t fmt_reg, conv_fmt_reg;
  logic sign_reg, msb_reg, test_reg, sw_pd_reg, cal_busy_reg, valid_reg, done_reg;
  logic [1:0] acq_sel_reg;
  logic [5:0] cnt_reg;
  logic [3:0] mux_reg;
  logic [12:0] result_reg;
  logic [16:0] out_word_reg;
  logic [4:0] out_len_reg;
  logic show_status_reg, dirty_reg, en_reg;
  wire pd_eff = pd_s2_reg | sw_pd_reg;
  wire busy = (state_reg != ST_IDLE);
  wire converting = (state_reg == ST_ACQ) | (state_reg == ST_CONV);
  wire fmt_start = (fsel == `ADSIC_SEL_8) ? 1'b0 : 1'b1;
  adsic_fmt_t fmt_new;
  assign fmt_new = (fsel == `ADSIC_SEL_8) ? FMT_8 : ((fsel == `ADSIC_SEL_16) ? FMT_16 : FMT_12);
  wire [5:0] acq_len = (acq_sel_reg == 2'h0) ? `ADSIC_ACQ_6 :
                       (acq_sel_reg == 2'h1) ? `ADSIC_ACQ_10 :
                       (acq_sel_reg == 2'h2) ? `ADSIC_ACQ_18 : `ADSIC_ACQ_34;
  wire [5:0] conv_len = (conv_fmt_reg == FMT_8) ? `ADSIC_CONV8_CCLKS : `ADSIC_CONV12_CCLKS;
  wire cnt_end = conversion_clock_tick & (cnt_reg == 6'h01);
  wire start_ok = do_conv & ~pd_eff & ~busy;
  wire abort = busy & (pd_eff | (do_status & converting));
  wire conv_end = (state_reg == ST_CONV) & cnt_end & ~abort;
  wire cal_end = (state_reg == ST_CAL) & cnt_end & ~abort;
  wire [4:0] base_len = (conv_fmt_reg == FMT_8) ? `ADSIC_LEN_8 :
                        (conv_fmt_reg == FMT_16) ? `ADSIC_LEN_16 : `ADSIC_LEN_12;
  wire sign_next = do_sign ? instr_reg[0] : sign_reg;
  wire [4:0] len_now = base_len + {4'h0, sign_next};
  wire [8:0] status_word = {test_reg, msb_reg, sign_reg, fmt_reg == FMT_16, fmt_reg == FMT_12,
                            fmt_reg == FMT_8, cal_busy_reg, pd_eff, 1'b0};
  wire fmt_fresh = conv_end | do_sign;

  // left-aligned serial word: low len bits of the value, optionally reversed
  function automatic logic [16:0] adsic_pack(input logic [16:0] v, input logic [4:0] len,
                                             input logic msb);
    logic [16:0] r;
    r = 17'h00000;
    for (int j = 0; j < 17; j++) begin
      if (j < int'(len)) begin
        r[j] = msb ? v[j] : v[int'(len) - 1 - j];
      end
    end
    return r << (5'd17 - len);
  endfunction : adsic_pack

  wire [12:0] res_src = conv_end ? adc_result : result_reg;
  wire [16:0] res_ext = (conv_fmt_reg == FMT_8) ? {{8{res_src[12]}}, res_src[12:4]} :
                                                  {{4{res_src[12]}}, res_src};
  wire [16:0] word_result = adsic_pack(res_ext, len_now, msb_reg);
  wire [16:0] word_status = adsic_pack({8'h00, status_word}, out_len_reg, 1'b1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          state_next = ST_ACQ;
        end else if ((do_cal | do_zero) & ~pd_eff) begin
          state_next = ST_CAL;
        end
      end
      ST_ACQ: begin
        if (cnt_end) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV, ST_CAL: begin
        if (cnt_end) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next == ST_ACQ) begin
        cnt_reg <= acq_len;
      end else if (state_reg == ST_IDLE && state_next == ST_CAL) begin
        cnt_reg <= do_cal ? `ADSIC_CAL_CCLKS : `ADSIC_ZERO_CCLKS;
      end else if (state_reg == ST_ACQ && cnt_end) begin
        cnt_reg <= conv_len;
      end else if (conversion_clock_tick && cnt_reg != 6'h00) begin
        cnt_reg <= cnt_reg - 6'h01;
      end
    end
  end

  // configuration, defaults at power-on
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fmt_reg <= FMT_12;
      conv_fmt_reg <= FMT_12;
      sign_reg <= 1'b1;
      msb_reg <= 1'b1;
      acq_sel_reg <= `ADSIC_ACQ_SEL_RST;
      test_reg <= 1'b0;
      sw_pd_reg <= 1'b0;
      mux_reg <= 4'h0;
    end else begin
      if (start_ok) begin
        fmt_reg <= fmt_new;
        conv_fmt_reg <= fmt_new;
        msb_reg <= ~instr_reg[5];
        mux_reg <= fmt_start ? instr_reg[3:0] : instr_reg[3:0];
      end
      if (do_sign) begin
        sign_reg <= instr_reg[0];
      end
      if (do_acq) begin
        acq_sel_reg <= {instr_reg[0], instr_reg[1]};
      end
      if (do_mode) begin
        test_reg <= instr_reg[0];
      end
      // software power-down wins over a clear in the same cycle
      if (do_pwrdn) begin
        sw_pd_reg <= 1'b1;
      end else if (do_pwrup | pd_fall) begin
        sw_pd_reg <= 1'b0;
      end
    end
  end

  // result, output word and status flags
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      result_reg <= 13'h0000;
      out_word_reg <= 17'h00000;
      out_len_reg <= `ADSIC_LEN_RST;
      show_status_reg <= 1'b0;
      cal_busy_reg <= 1'b0;
      valid_reg <= 1'b0;
      done_reg <= 1'b0;
      en_reg <= 1'b1;
    end else begin
      en_reg <= ~pd_eff;
      cal_busy_reg <= (state_next == ST_CAL);
      if (start_ok) begin
        done_reg <= 1'b0;
      end else if (conv_end) begin
        done_reg <= 1'b1;
      end
      if (conv_end) begin
        result_reg <= adc_result;
        valid_reg <= 1'b1;
      end else if (abort & converting) begin
        valid_reg <= 1'b0;
      end
      if (cal_end) begin
        out_word_reg <= `ADSIC_CAL_JUNK;
        show_status_reg <= 1'b0;
      end else if (do_status) begin
        out_word_reg <= word_status;
        show_status_reg <= 1'b1;
      end else if (fmt_fresh) begin
        out_word_reg <= word_result;
        out_len_reg <= len_now;
        show_status_reg <= 1'b0;
      end
    end
  end

  // publish a new word only once the previous one has been taken
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      xfer_word_reg <= 17'h00000;
      xfer_len_reg <= `ADSIC_LEN_RST;
      pub_tgl_reg <= 1'b0;
      dirty_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      // raised one clock after the word settles, dropped once the link has taken it
      pend_reg <= (pub_tgl_reg != ack_s2_reg);
      if (pub_tgl_reg == ack_s2_reg && !pend_reg && dirty_reg) begin
        xfer_word_reg <= out_word_reg;
        xfer_len_reg <= out_len_reg;
        pub_tgl_reg <= ~pub_tgl_reg;
        dirty_reg <= cal_end | do_status | fmt_fresh;
      end else if (cal_end | do_status | fmt_fresh) begin
        dirty_reg <= 1'b1;
      end
    end
  end

  assign conv_done = done_reg;
  assign converter_enable = en_reg;
  assign mux_select = mux_reg;
  assign test_drive_en = test_reg;
  assign result_valid = valid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_status_abort;
    do_status && converting |=> state_reg == ST_IDLE;
  endproperty
  a_status_abort: assert property (p_status_abort) else $error("status read did not end conversion");

  property p_cfg_no_start;
    (do_sign || do_acq) && !busy |=> state_reg == ST_IDLE;
  endproperty
  a_cfg_no_start: assert property (p_cfg_no_start) else $error("configuration started a conversion");

  sequence s_start;
    start_ok;
  endsequence
  sequence s_acq_loaded;
    state_reg == ST_ACQ && cnt_reg == $past(acq_len);
  endsequence
  property p_conv_start;
    s_start |=> s_acq_loaded;
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("conversion instruction did not start");

  property p_pd_enable;
    pd_eff |=> !converter_enable;
  endproperty
  a_pd_enable: assert property (p_pd_enable) else $error("converter enabled in power-down");

  property p_pin_wake;
    do_pwrup && pd_s2_reg |=> !converter_enable ##1 !converter_enable;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("woke while pin held power-down");

  property p_pin_pulse;
    pd_fall && !do_pwrdn |=> !sw_pd_reg;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("pin pulse did not clear power-down");

  property p_pd_abort;
    pd_eff && converting |=> state_reg == ST_IDLE && !result_valid;
  endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("power-down did not abort");

  property p_trig_hold;
    instr_evt && trig_reg && !busy |=> state_reg == ST_IDLE && $stable(mux_select);
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("read-only transfer changed state");

  property p_len_change;
    $changed(out_len_reg) |-> $past(fmt_fresh);
  endproperty
  a_len_change: assert property (p_len_change) else $error("word length changed without cause");

  property p_done;
    conv_end |=> conv_done && result_reg == $past(adc_result);
  endproperty
  a_done: assert property (p_done) else $error("done not raised at conversion end");

  property p_mode;
    do_mode |=> test_drive_en == $past(instr_reg[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode instruction not applied");
endmodule : adsic_core

// ==== testbench/adsic_host_model.sv ====
// host model: serial master of the instruction link
`timescale 1ns/1ps
module adsic_host_model (
  output logic serial_clock,
  output logic cs_b,
  output logic serial_instr_in,
  output logic conv_b,
  input wire logic serial_data_out
);
  // ------------------------------
  // idle: clock still, select high
  // ------------------------------
  initial begin
    serial_clock = 1'b0;
    cs_b = 1'b1;
    serial_instr_in = 1'b0;
    conv_b = 1'b0;
  end
  // ------------------------------
  // one transfer of n link clocks
  // ------------------------------
  // n comes from the caller, sized by the last format
  task automatic xfer(input logic [7:0] ins, input int n, input logic rd, input logic hold, output logic [16:0] w);
    w = 17'h0;
    #3;
    cs_b = 1'b0;
    conv_b = rd;
    for (int k = 0; k < n; k++) begin
      // past bit 7 the line toggles, so a stale level is never mistaken for data
      serial_instr_in = (k < 8) ? ins[k] : ~serial_instr_in;
      #8 serial_clock = 1'b1;
      #8 w = {w[15:0], serial_data_out};
      #8 serial_clock = 1'b0;
      #8;
    end
    cs_b = hold ? 1'b0 : 1'b1;
    serial_instr_in = ~serial_instr_in;
    #128;
  endtask : xfer
endmodule : adsic_host_model

// ==== testbench/adsic_core_tb_top.sv ====
// self-checking bench for the serial instruction and control block
`timescale 1ns/1ps
module adsic_core_tb_top;
  import adsic_pkg::*;
  // ------------------------------
  // signals
  // ------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic power_down_pin = 1'b0;
  logic conversion_clock = 1'b0;
  logic [12:0] adc_result = 13'h1a5c;
  logic [2:0] cdiv = 3'h0;
  logic serial_clock, cs_b, serial_instr_in, conv_b;
  logic serial_data_out, conv_done, converter_enable, test_drive_en, result_valid;
  logic [3:0] mux_select;
  logic [16:0] w;
  logic [7:0] seq [7] = '{8'h70, 8'h50, 8'hd0, 8'hf0, 8'h50, 8'hb1, 8'h72};
  logic [7:0] acq_ins [4] = '{8'h70, 8'h71, 8'h73, 8'h72};
  int acq_len [4] = '{6, 18, 34, 10};
  int tm [4];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  // ------------------------------
  // clocks and timeout
  // ------------------------------
  always #2 clock = ~clock;
  // conversion_clock at an eighth of clock, inside the clock/2 limit
  always @(negedge clock) begin
    cdiv <= cdiv + 3'h1;
    conversion_clock <= cdiv[2];
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  adsic_core adsic_core_inst (
    .clock(clock),
    .rst_b(rst_b),
    .serial_clock(serial_clock),
    .cs_b(cs_b),
    .serial_instr_in(serial_instr_in),
    .conv_b(conv_b),
    .power_down_pin(power_down_pin),
    .conversion_clock(conversion_clock),
    .adc_result(adc_result),
    .serial_data_out(serial_data_out),
    .conv_done(conv_done),
    .converter_enable(converter_enable),
    .mux_select(mux_select),
    .test_drive_en(test_drive_en),
    .result_valid(result_valid)
  );
  adsic_host_model adsic_host_model_inst (
    .serial_clock(serial_clock),
    .cs_b(cs_b),
    .serial_instr_in(serial_instr_in),
    .conv_b(conv_b),
    .serial_data_out(serial_data_out)
  );
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp
  task automatic cmp_rng(input int got, input int lo, input int hi, input string m);
    compares++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %0d not in %0d..%0d", $time, m, got, lo, hi);
    end
  endtask : cmp_rng
  function automatic logic [16:0] pins();
    return 17'({conv_done, converter_enable, test_drive_en, result_valid, mux_select});
  endfunction : pins
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic io(input logic [7:0] i, input int n, input logic rd = 1'b0, input logic hold = 1'b0);
    adsic_host_model_inst.xfer(i, n, rd, hold, w);
  endtask : io
  task automatic pd(input logic v);
    @(negedge clock);
    power_down_pin = v;
    tick(20);
  endtask : pd
  task automatic wait_done(output int c);
    c = 0;
    while (conv_done !== 1'b1 && c < 4000) begin
      @(negedge clock);
      c++;
    end
  endtask : wait_done
  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    tick(3);
    cmp(pins(), 17'h40, "reset pins");
    rst_b = 1'b1;
    tick(4);
    io(8'h10, 8);
    tick(750);
    io(8'h30, 8);
    io(8'h30, 13);
    cmp(w, 17'h0d0, "status");
    io(8'h05, 13);
    cmp(w, 17'h0d0, "status again");
    wait_done(tm[0]);
    cmp(pins(), 17'hd5, "conv end");
    io(8'h0a, 13, 1'b1);
    cmp(w, 17'h1a5c, "result");
    cmp(pins(), 17'hd5, "read only");
    io(8'h70, 13);
    cmp(w, 17'h1a5c, "after acq");
    cmp(pins(), 17'hd5, "acq no conv");
    io(8'hb0, 13);
    cmp(w, 17'h1a5c, "after sign off");
    io(8'h72, 12);
    cmp(w, 17'h0a5c, "no sign");
    io(8'hb1, 12);
    cmp(w, 17'h0a5c, "still no sign");
    for (int i = 0; i < 4; i++) begin
      io(acq_ins[i], 13);
      io(8'h05, 13);
      wait_done(tm[i]);
    end
    // differences cancel the fixed start latency
    for (int i = 1; i < 4; i++) begin
      cmp_rng(tm[i] - tm[0], (acq_len[i] - 6) * 8 - 12, (acq_len[i] - 6) * 8 + 12, "acq length");
    end
    adc_result = 13'h0b37;
    io(8'h49, 13);
    wait_done(tm[0]);
    cmp(pins(), 17'hd9, "eight bit conv");
    io(8'h00, 9, 1'b1);
    cmp(w, 17'h0b3, "eight bit word");
    io(8'h05, 9);
    tick(40);
    pd(1'b1);
    cmp(17'({converter_enable, result_valid}), 17'h0, "pd abort");
    pd(1'b0);
    cmp(17'(converter_enable), 17'h1, "pin low");
    io(8'h05, 13);
    wait_done(tm[0]);
    cmp(17'(result_valid), 17'h1, "valid");
    io(8'h05, 13);
    io(8'h30, 13);
    cmp(17'(result_valid), 17'h0, "status abort");
    io(8'hd0, 8);
    cmp(17'(converter_enable), 17'h0, "soft down");
    io(8'h30, 13);
    io(8'h30, 13);
    cmp(w, 17'h0d2, "status in pd");
    io(8'h50, 8);
    cmp(17'(converter_enable), 17'h1, "soft up");
    pd(1'b1);
    io(8'h50, 8);
    cmp(17'(converter_enable), 17'h0, "pin wins");
    pd(1'b0);
    io(8'hd0, 8);
    pd(1'b1);
    pd(1'b0);
    cmp(17'(converter_enable), 17'h1, "pin pulse");
    io(8'hf1, 8);
    cmp(17'(test_drive_en), 17'h1, "test on");
    io(8'h30, 13);
    io(8'h30, 13);
    cmp(w, 17'h1d0, "test status");
    foreach (seq[i]) io(seq[i], 8);
    cmp(17'(test_drive_en), 17'h0, "user mode");
    io(8'hff, 3);
    tick(1);
    adc_result = 13'h0f0f;
    io(8'h03, 13, 1'b0, 1'b1);
    wait_done(tm[0]);
    io(8'h00, 13, 1'b1, 1'b1);
    cmp(w, 17'h0f0f, "held select");
    cmp(pins(), 17'hd3, "channel three");
    io(8'h00, 13, 1'b1);
    complete_run();
  end
endmodule : adsic_core_tb_top
